// ==== pkg/sadr_defs.vh ====
`ifndef SADR_DEFS_VH
`define SADR_DEFS_VH

// Area field of the system address
`define SADR_AREA_MSB        31
`define SADR_AREA_LSB        28
`define SADR_AREA_W          4
`define SADR_AREA_INTERNAL   4'h0
`define SADR_AREA_EXT_FIRST  4'h1
`define SADR_AREA_EXT_LAST   4'h8
`define SADR_AREA_PERIPH     4'hF
`define SADR_EXT_SELECTS     8

// Slot field inside the internal area, 1 MB per slot
`define SADR_SLOT_MSB        27
`define SADR_SLOT_LSB        20
`define SADR_SLOT_W          8
`define SADR_OFFSET_W        20
`define SADR_SLOT_BOOT       8'h00
`define SADR_SLOT_FLASH      8'h01
`define SADR_SLOT_SRAM       8'h02
`define SADR_SLOT_ROM        8'h03

// Memory sizes of the larger variants
`define SADR_SRAM_BYTES      32768
`define SADR_FLASH_BANKS     2
`define SADR_FLASH_PAGES     1024
`define SADR_PAGE_BYTES      256
`define SADR_ROM_BYTES       1048576

// Boot selection bit state after power-on
`define SADR_BOOT_INIT       1'b0

`endif

// ==== src/sadr_boot_bit.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sadr_defs.vh"

module sadr_boot_bit #(
	parameter [0:0] INIT = `SADR_BOOT_INIT
) (
	// Power-on reset only; system reset leaves the bit alone
	input  wire clk,
	input  wire por,
	// Commands from the flash controller
	input  wire set_cmd,
	input  wire clear_cmd,
	input  wire erase,
	// Stored bit
	output reg  bit_value
);
	always @(posedge clk or posedge por) begin
		if (por)
			bit_value <= INIT;
		else if (erase)
			bit_value <= 1'b0;
		else if (set_cmd)
			bit_value <= 1'b1;
		else if (clear_cmd)
			bit_value <= 1'b0;
	end
endmodule

`default_nettype wire

// ==== src/sadr_decoder.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sadr_defs.vh"

module sadr_decoder #(
	parameter SRAM_BYTES  = `SADR_SRAM_BYTES,
	parameter FLASH_BANKS = `SADR_FLASH_BANKS,
	parameter FLASH_PAGES = `SADR_FLASH_PAGES,
	parameter PAGE_BYTES  = `SADR_PAGE_BYTES,
	parameter ROM_BYTES   = `SADR_ROM_BYTES
) (
	// Clock and resets
	input  wire                          CLOCK,
	input  wire                          RST,
	input  wire                          NV_POR,
	// Master request
	input  wire                          REQ_VALID,
	input  wire [31:0]                   REQ_ADDR,
	input  wire                          REQ_WRITE,
	input  wire [31:0]                   REQ_WDATA,
	// Remap and boot selection control
	input  wire                          REMAP_CMD,
	input  wire                          NV_SET_CMD,
	input  wire                          NV_CLEAR_CMD,
	input  wire                          ERASE,
	// Decode result
	output reg                           RSP_VALID,
	output reg                           ABORT,
	output reg  [`SADR_EXT_SELECTS-1:0]  EXTERNAL_SELECT_LINE_N,
	output reg                           PERIPH_SEL,
	output reg  [31:0]                   FWD_ADDR,
	output reg                           FLASH_SEL,
	output reg  [$clog2(FLASH_BANKS)+(FLASH_BANKS<2)-1:0] FLASH_BANK,
	output reg                           SRAM_SEL,
	output reg                           ROM_SEL,
	output reg  [`SADR_OFFSET_W-1:0]     MEM_OFFSET,
	// State
	output reg                           REMAPPED,
	output reg                           BOOT_FLASH,
	// Flash write buffer read port
	input  wire [$clog2(PAGE_BYTES/4)-1:0] WBUF_RD_INDEX,
	output reg  [31:0]                   WBUF_RD_DATA
);
	localparam BANK_BYTES  = FLASH_PAGES * PAGE_BYTES;
	localparam FLASH_BYTES = FLASH_BANKS * BANK_BYTES;
	localparam BANK_W      = (FLASH_BANKS > 1) ? $clog2(FLASH_BANKS) : 1;
	localparam BANK_LSB    = $clog2(BANK_BYTES);
	localparam WBUF_WORDS  = PAGE_BYTES / 4;
	localparam WBUF_IDX_W  = $clog2(WBUF_WORDS);

	// Area decode
	wire [`SADR_AREA_W-1:0]      area;
	wire                         is_ext;
	wire                         is_internal;
	wire                         is_periph;
	wire [`SADR_AREA_W-1:0]      ext_index;
	// Second-level decode
	wire                         boot_bit;
	wire                         m_flash;
	wire                         m_sram;
	wire                         m_rom;
	wire                         m_hole;
	wire [`SADR_OFFSET_W-1:0]    m_offset;
	// Write buffer
	wire                         wbuf_write;
	wire [WBUF_IDX_W-1:0]        wbuf_index;
	reg  [31:0]                  wbuf [0:WBUF_WORDS-1];

	// Remap state and next values of the registered outputs
	reg                          remap;
	reg                          next_rsp_valid;
	reg                          next_abort;
	reg  [`SADR_EXT_SELECTS-1:0] next_select_n;
	reg                          next_periph_sel;
	reg                          next_flash_sel;
	reg  [BANK_W-1:0]            next_flash_bank;
	reg                          next_sram_sel;
	reg                          next_rom_sel;
	reg  [`SADR_OFFSET_W-1:0]    next_mem_offset;

	assign area = REQ_ADDR[`SADR_AREA_MSB:`SADR_AREA_LSB];
	assign is_ext = (area >= `SADR_AREA_EXT_FIRST)
	                && (area <= `SADR_AREA_EXT_LAST);
	assign is_internal = (area == `SADR_AREA_INTERNAL);
	assign is_periph   = (area == `SADR_AREA_PERIPH);
	assign ext_index = area - `SADR_AREA_EXT_FIRST;

	sadr_boot_bit u_boot (
		.clk       (CLOCK),
		.por       (NV_POR),
		.set_cmd   (NV_SET_CMD),
		.clear_cmd (NV_CLEAR_CMD),
		.erase     (ERASE),
		.bit_value (boot_bit)
	);

	// Second-level decode of the internal area
	sadr_slot_map #(
		.SRAM_BYTES  (SRAM_BYTES),
		.FLASH_BYTES (FLASH_BYTES),
		.ROM_BYTES   (ROM_BYTES)
	) u_slots (
		.area_addr  (REQ_ADDR[27:0]),
		.remap      (remap),
		.boot_flash (boot_bit),
		.sel_flash  (m_flash),
		.sel_sram   (m_sram),
		.sel_rom    (m_rom),
		.hole       (m_hole),
		.offset     (m_offset)
	);

	// Remap is one-way until the next system reset
	always @(posedge CLOCK or posedge RST) begin
		if (RST)
			remap <= 1'b0;
		else if (REMAP_CMD)
			remap <= 1'b1;
	end

	// Each request is judged on its own; nothing is held between cycles
	always @* begin
		next_rsp_valid  = REQ_VALID;
		next_abort      = 1'b0;
		next_select_n   = {`SADR_EXT_SELECTS{1'b1}};
		next_periph_sel = 1'b0;
		next_flash_sel  = 1'b0;
		next_sram_sel   = 1'b0;
		next_rom_sel    = 1'b0;
		if (REQ_VALID) begin
			if (is_ext) begin
				next_select_n[ext_index[2:0]] = 1'b0;
			end else if (is_internal) begin
				next_abort     = m_hole;
				next_flash_sel = m_flash;
				next_sram_sel  = m_sram;
				next_rom_sel   = m_rom;
			end else if (is_periph) begin
				next_periph_sel = 1'b1;
			end else begin
				next_abort = 1'b1;
			end
		end
	end

	// Offset and bank follow the slot decode for any area and any valid; a hole gives zero offset and bank
	always @* begin
		next_mem_offset = m_offset;
		next_flash_bank = {BANK_W{1'b0}};
		if (FLASH_BANKS > 1)
			next_flash_bank = m_offset[BANK_LSB+BANK_W-1:BANK_LSB];
	end

	// Flash writes land in the page buffer, one word per access
	assign wbuf_write = REQ_VALID && REQ_WRITE
	                    && (area == `SADR_AREA_INTERNAL) && m_flash;
	assign wbuf_index = m_offset[WBUF_IDX_W+1:2];

	always @(posedge CLOCK) begin
		if (wbuf_write)
			wbuf[wbuf_index] <= REQ_WDATA;
	end

	// Buffer is not reset; only written words are meaningful
	always @(posedge CLOCK or posedge RST) begin
		if (RST)
			WBUF_RD_DATA <= 32'h0000_0000;
		else
			WBUF_RD_DATA <= wbuf[WBUF_RD_INDEX];
	end

	// Response and target selects
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			RSP_VALID              <= 1'b0;
			ABORT                  <= 1'b0;
			EXTERNAL_SELECT_LINE_N <= {`SADR_EXT_SELECTS{1'b1}};
			PERIPH_SEL             <= 1'b0;
			FLASH_SEL              <= 1'b0;
			SRAM_SEL               <= 1'b0;
			ROM_SEL                <= 1'b0;
		end else begin
			RSP_VALID              <= next_rsp_valid;
			ABORT                  <= next_abort;
			EXTERNAL_SELECT_LINE_N <= next_select_n;
			PERIPH_SEL             <= next_periph_sel;
			FLASH_SEL              <= next_flash_sel;
			SRAM_SEL               <= next_sram_sel;
			ROM_SEL                <= next_rom_sel;
		end
	end

	// Address forwarded to the selected target
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			FWD_ADDR   <= 32'h0000_0000;
			FLASH_BANK <= {BANK_W{1'b0}};
			MEM_OFFSET <= {`SADR_OFFSET_W{1'b0}};
		end else begin
			FWD_ADDR   <= REQ_ADDR;
			FLASH_BANK <= next_flash_bank;
			MEM_OFFSET <= next_mem_offset;
		end
	end

	// Mapping state seen by the rest of the system
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			REMAPPED   <= 1'b0;
			BOOT_FLASH <= 1'b0;
		end else begin
			REMAPPED   <= remap;
			BOOT_FLASH <= boot_bit;
		end
	end
endmodule

`default_nettype wire

// ==== src/sadr_slot_map.v ====
`timescale 1ns/1ps
`default_nettype none
`include "sadr_defs.vh"

module sadr_slot_map #(
	parameter SRAM_BYTES  = `SADR_SRAM_BYTES,
	parameter FLASH_BYTES = `SADR_FLASH_BANKS * `SADR_FLASH_PAGES
	                        * `SADR_PAGE_BYTES,
	parameter ROM_BYTES   = `SADR_ROM_BYTES
) (
	// Address inside the internal area
	input  wire [27:0]                  area_addr,
	// Mapping state
	input  wire                         remap,
	input  wire                         boot_flash,
	// Decoded target
	output reg                          sel_flash,
	output reg                          sel_sram,
	output reg                          sel_rom,
	output reg                          hole,
	output reg  [`SADR_OFFSET_W-1:0]    offset
);
	localparam [31:0] SRAM_MASK  = SRAM_BYTES - 1;
	localparam [31:0] FLASH_MASK = FLASH_BYTES - 1;
	localparam [31:0] ROM_MASK   = ROM_BYTES - 1;

	wire [`SADR_SLOT_W-1:0]   slot;
	wire [`SADR_OFFSET_W-1:0] raw;

	assign slot = area_addr[`SADR_SLOT_MSB:`SADR_SLOT_LSB];
	assign raw  = area_addr[`SADR_OFFSET_W-1:0];

	always @* begin
		sel_flash = 1'b0;
		sel_sram  = 1'b0;
		sel_rom   = 1'b0;
		hole      = 1'b0;
		case (slot)
			`SADR_SLOT_BOOT: begin
				if (remap)
					sel_sram = 1'b1;
				else if (boot_flash)
					sel_flash = 1'b1;
				else
					sel_rom = 1'b1;
			end
			`SADR_SLOT_FLASH: sel_flash = 1'b1;
			`SADR_SLOT_SRAM:  sel_sram = 1'b1;
			`SADR_SLOT_ROM:   sel_rom = 1'b1;
			default:          hole = 1'b1;
		endcase
		// Small memories repeat through their slot
		if (sel_sram)
			offset = raw & SRAM_MASK[`SADR_OFFSET_W-1:0];
		else if (sel_flash)
			offset = raw & FLASH_MASK[`SADR_OFFSET_W-1:0];
		else if (sel_rom)
			offset = raw & ROM_MASK[`SADR_OFFSET_W-1:0];
		else
			offset = {`SADR_OFFSET_W{1'b0}};
	end
endmodule

`default_nettype wire

// ==== verification/sadr_decoder_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module sadr_decoder_chk (
	// Clock and reset
	input wire logic        CLOCK,
	input wire logic        RST,
	// Request side
	input wire logic        REQ_VALID,
	input wire logic [31:0] REQ_ADDR,
	input wire logic        REMAP_CMD,
	// Decode result
	input wire logic        RSP_VALID,
	input wire logic        ABORT,
	input wire logic [7:0]  EXTERNAL_SELECT_LINE_N,
	input wire logic        PERIPH_SEL,
	input wire logic [31:0] FWD_ADDR,
	input wire logic        FLASH_SEL,
	input wire logic        SRAM_SEL,
	input wire logic        ROM_SEL,
	input wire logic [19:0] MEM_OFFSET,
	input wire logic        BOOT_FLASH
);
	wire  [3:0]  a = REQ_ADDR[31:28];
	wire  [11:0] s = REQ_ADDR[31:20];
	wire  [14:0] lo = REQ_ADDR[14:0];
	wire         q = REQ_VALID;
	wire         no_ext = EXTERNAL_SELECT_LINE_N == 8'hFF;
	logic        rm;
	// Own copy of the remap state, so the alias is not judged by the
	// design's own flag
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST)
			rm <= 1'b0;
		else if (REMAP_CMD)
			rm <= 1'b1;
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	fwd_addr_a: assert property (q |=>
		RSP_VALID && FWD_ADDR == $past(REQ_ADDR)) else $error("not forwarded");
	one_shot_a: assert property (!q |=> !RSP_VALID)
		else $error("extra response");
	ext_sel_a: assert property (q && a inside {[1:8]} |=> !ABORT &&
		EXTERNAL_SELECT_LINE_N == ~(8'h01 << ($past(a) - 4'h1)))
		else $error("bad select");
	periph_a: assert property (q && a == 4'hF |=>
		PERIPH_SEL && !ABORT && no_ext) else $error("no peripheral");
	unused_abort_a: assert property (q && a inside {[9:14]} |=>
		ABORT && !PERIPH_SEL && no_ext) else $error("no abort");
	int_hole_a: assert property (q && a == 4'h0 && s > 12'h003 |=>
		ABORT && !(FLASH_SEL || SRAM_SEL || ROM_SEL)) else $error("hole");
	fixed_slot_a: assert property (q && s inside {1, 3} |=>
		{FLASH_SEL, ROM_SEL} == {$past(s) == 12'h001, $past(s) == 12'h003})
		else $error("bad slot");
	sram_slot_a: assert property (q && s == 12'h002 |=> SRAM_SEL &&
		MEM_OFFSET == {5'h00, $past(lo)}) else $error("bad sram");
	remap_alias_a: assert property (q && s == 12'h000 && rm |=>
		SRAM_SEL && !FLASH_SEL && !ROM_SEL) else $error("no alias");
	boot_alias_a: assert property (q && s == 12'h000 && !rm |=>
		FLASH_SEL == BOOT_FLASH && ROM_SEL != BOOT_FLASH && !SRAM_SEL)
		else $error("bad boot alias");
	cover property (q && a == 4'h5);
	cover property (q && s == 12'h000 && rm);
	cover property (q && a == 4'hB);
endmodule
bind sadr_decoder sadr_decoder_chk sadr_decoder_chk_inst (.*);
`default_nettype wire

// ==== verification/sadr_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sadr_master_model (
	// Clock
	input  wire logic        clk,
	// Request to the decoder
	output var  logic        req_valid,
	output var  logic        req_write,
	output var  logic [31:0] req_addr,
	output var  logic [31:0] req_wdata
);
	initial begin
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr  = 32'h0000_0000;
		req_wdata = 32'h0000_0000;
	end
	// Idle address and data are inverted so a stale value never
	// passes for a fresh request
	task automatic issue(input logic [31:0] a, input logic w,
		input logic [31:0] d, input int gap);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr  <= a;
		req_wdata <= d;
		@(posedge clk);
		req_valid <= 1'b0;
		req_write <= 1'b0;
		req_addr  <= ~a;
		req_wdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ==== verification/system_address_decoder_remap_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module system_address_decoder_remap_tb;
	logic        CLOCK, RST, NV_POR, REMAP_CMD;
	logic        NV_SET_CMD, NV_CLEAR_CMD, ERASE;
	logic [5:0]  WBUF_RD_INDEX;
	wire         REQ_VALID, REQ_WRITE, RSP_VALID, ABORT, PERIPH_SEL;
	wire         FLASH_SEL, SRAM_SEL, ROM_SEL, REMAPPED, BOOT_FLASH;
	wire  [31:0] REQ_ADDR, REQ_WDATA, FWD_ADDR, WBUF_RD_DATA;
	wire  [7:0]  EXTERNAL_SELECT_LINE_N;
	wire  [0:0]  FLASH_BANK;
	wire  [19:0] MEM_OFFSET;
	wire  [13:0] st = {RSP_VALID, ABORT, PERIPH_SEL, FLASH_SEL, SRAM_SEL,
		ROM_SEL, EXTERNAL_SELECT_LINE_N};
	localparam [13:0] e_rom = 14'h21FF, e_fl = 14'h24FF, e_sr = 14'h22FF;
	localparam [13:0] e_ab = 14'h30FF, e_pe = 14'h28FF;
	int          failures, tests_run;
	sadr_decoder sadr_decoder_inst (.CLOCK(CLOCK), .RST(RST),
		.NV_POR(NV_POR), .REQ_VALID(REQ_VALID), .REQ_ADDR(REQ_ADDR),
		.REQ_WRITE(REQ_WRITE), .REQ_WDATA(REQ_WDATA), .REMAP_CMD(REMAP_CMD),
		.NV_SET_CMD(NV_SET_CMD), .NV_CLEAR_CMD(NV_CLEAR_CMD), .ERASE(ERASE),
		.RSP_VALID(RSP_VALID), .ABORT(ABORT), .PERIPH_SEL(PERIPH_SEL),
		.EXTERNAL_SELECT_LINE_N(EXTERNAL_SELECT_LINE_N), .ROM_SEL(ROM_SEL),
		.FWD_ADDR(FWD_ADDR), .FLASH_SEL(FLASH_SEL), .FLASH_BANK(FLASH_BANK),
		.SRAM_SEL(SRAM_SEL), .MEM_OFFSET(MEM_OFFSET), .REMAPPED(REMAPPED),
		.BOOT_FLASH(BOOT_FLASH), .WBUF_RD_INDEX(WBUF_RD_INDEX),
		.WBUF_RD_DATA(WBUF_RD_DATA));
	sadr_master_model sadr_master_model_inst (.clk(CLOCK),
		.req_valid(REQ_VALID), .req_write(REQ_WRITE),
		.req_addr(REQ_ADDR), .req_wdata(REQ_WDATA));
	initial begin
		CLOCK = 1'b0;
		forever #20 CLOCK = ~CLOCK;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task acc(input logic [31:0] a, input logic [13:0] e);
		sadr_master_model_inst.issue(a, 1'b0, 32'h0000_0000, 0);
		#1;
		chk(st, e);
	endtask
	task t_areas;
		for (int k = 1; k < 16; k++) begin
			acc({k[3:0], 28'h000_0010}, (k <= 8) ? {6'h20, ~(8'h01 << (k - 1))}
				: (k == 15) ? e_pe : e_ab);
			chk(FWD_ADDR, {k[3:0], 28'h000_0010});
		end
	endtask
	task t_slots;
		acc(32'h0010_0004, e_fl);
		chk(FLASH_BANK, 32'h0000_0000);
		acc(32'h0014_0000, e_fl);
		chk(FLASH_BANK, 32'h0000_0001);
		acc(32'h0020_8004, e_sr);
		chk(MEM_OFFSET, 32'h0000_0004);
		acc(32'h0030_0008, e_rom);
		acc(32'h0040_0000, e_ab);
		acc(32'h0000_0000, e_rom);
	endtask
	task t_boot;
		@(posedge CLOCK) NV_SET_CMD <= 1'b1;
		@(posedge CLOCK) NV_SET_CMD <= 1'b0;
		acc(32'h0000_0000, e_fl);
		@(posedge CLOCK) NV_CLEAR_CMD <= 1'b1;
		@(posedge CLOCK) NV_CLEAR_CMD <= 1'b0;
		acc(32'h0000_0000, e_rom);
		// Erase and set land together: erase must win
		@(posedge CLOCK) {ERASE, NV_SET_CMD} <= 2'b11;
		@(posedge CLOCK) {ERASE, NV_SET_CMD} <= 2'b00;
		acc(32'h0000_0000, e_rom);
		chk(BOOT_FLASH, 32'h0000_0000);
	endtask
	task t_remap;
		@(posedge CLOCK) NV_SET_CMD <= 1'b1;
		@(posedge CLOCK) {NV_SET_CMD, REMAP_CMD} <= 2'b01;
		@(posedge CLOCK) REMAP_CMD <= 1'b0;
		acc(32'h0000_0000, e_sr);
		acc(32'h0020_0000, e_sr);
		chk(REMAPPED, 32'h0000_0001);
		// System reset drops remap but keeps the boot bit
		@(posedge CLOCK) RST <= 1'b1;
		@(posedge CLOCK) RST <= 1'b0;
		acc(32'h0000_0000, e_fl);
		chk(REMAPPED, 32'h0000_0000);
		chk(BOOT_FLASH, 32'h0000_0001);
	endtask
	task t_wbuf;
		sadr_master_model_inst.issue(32'h0010_00FC, 1'b1, 32'h1234_5678, 3);
		@(posedge CLOCK) WBUF_RD_INDEX <= 6'h3F;
		@(posedge CLOCK);
		#1;
		chk(WBUF_RD_DATA, 32'h1234_5678);
	endtask
	task print_verdict;
		if (failures == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		{RST, NV_POR, REMAP_CMD, NV_SET_CMD, NV_CLEAR_CMD, ERASE} = 6'h30;
		WBUF_RD_INDEX = 6'h00;
		repeat (10) @(posedge CLOCK);
		{RST, NV_POR} <= 2'b00;
		t_areas;
		t_slots;
		t_boot;
		t_remap;
		t_wbuf;
		print_verdict;
	end
	initial begin
		#100000;
		failures++;
		print_verdict;
	end
endmodule
`default_nettype wire
